// ===== common/tla_pkg.sv
// Constants and types of the temperature limit alarm logic
package tla_pkg;

	localparam int TEMP_W = 8;
	localparam int ADDR_W = 4;
	localparam int HYST_W = 5;
	localparam int NCH    = 2;
	localparam int CH_LOC = 0;
	localparam int CH_REM = 1;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_LOCAL_TEMP  = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_TEMP = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CONFIG      = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_HIGH  = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_LOW   = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_HIGH = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_LOW  = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_TRIP  = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_TRIP = 4'h9;
	localparam logic [ADDR_W-1:0] OFF_HYST        = 4'hA;
	localparam logic [ADDR_W-1:0] OFF_OFFSET      = 4'hB;

	// Configuration fields
	localparam int CFG_MASK_BIT  = 7;
	localparam int CFG_SEL_BIT   = 5;
	localparam int CFG_COMP_BIT  = 4;
	localparam int CFG_RSVD_BIT  = 3;
	localparam logic [7:0] CFG_WR_MASK = 8'hB0;

	// Status fields
	localparam int ST_LOC_LOW  = 0;
	localparam int ST_LOC_HIGH = 1;
	localparam int ST_OPEN     = 2;
	localparam int ST_REM_LOW  = 3;
	localparam int ST_REM_HIGH = 4;
	localparam int ST_W        = 5;

	// Values after reset
	localparam logic [7:0]        RST_CONFIG = 8'h08;
	localparam logic [TEMP_W-1:0] RST_HIGH   = 8'h55;
	localparam logic [TEMP_W-1:0] RST_LOW    = 8'h00;
	localparam logic [TEMP_W-1:0] RST_TRIP   = 8'h55;
	localparam logic [HYST_W-1:0] RST_HYST   = 5'h0A;
	localparam logic [TEMP_W-1:0] RST_TEMP   = 8'h00;
	localparam logic [TEMP_W-1:0] RST_OFFSET = 8'h00;

	// Saturation bounds of the corrected remote result
	localparam logic signed [TEMP_W:0] SAT_MAX = 9'sh07F;
	localparam logic signed [TEMP_W:0] SAT_MIN = -9'sh080;

	typedef enum logic [2:0] {
		TLA_IDLE     = 3'b001,
		TLA_ASSERTED = 3'b010,
		TLA_SERVICED = 3'b100
	} tla_alert_t;

endpackage

// ===== core/tla_alarm.sv
// Alarm and trip logic of a two-channel temperature monitor
//
// Contract
// RL1: Alarm asserts when either channel result is above its high limit.
// RL2: Alarm also asserts when a result is at or below its low limit.
// RL3: Remote open-sensor fault asserts the alarm like a limit violation.
// RL4: Alarm releases only after service, condition gone and flags cleared.
// RL5: Fail-safe trip is never masked; only the alarm has a mask.
// RL6: Fail-safe trip asserts when either result exceeds its trip limit.
// RL7: Fail-safe trip releases itself at trip limit minus hysteresis.
// RL8: Both fail-safe trip limits reset to 85 degrees.
// RL9: One hysteresis for both channels, reset 10, writable 0 to 31.
// RL10: Software should program trip limits at or above high limits.
// RL11: Shared pin acts as alarm or as second trip output.
// RL12: Second trip asserts when a result exceeds its high limit, unmasked.
// RL13: Second trip releases at high limit minus the same hysteresis.
// RL14: Either channel alone asserts both trip outputs.
// RL15: Configuration bit 4 set disables remote gain compensation.
// RL16: Signed offset is added to each remote result before use.
// RL17: Alert response read is answered with the seven-bit device address.
// RL18: Status bit 2 sets when open sensor is seen at conversion start.
// RL19: Configuration bit 7 masks the alarm; no effect in trip mode.
// RL20: Configuration bit 5 selects shared pin: 0 alarm, 1 second trip.
// RL21: Comparisons re-evaluate on any result, limit or hysteresis change.
// RL22: Active-low outputs are open-drain pull-down enables for wired-OR.
`timescale 1ns/1ps

module tla_alarm #(
	parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [tla_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_we,
	input  wire logic                          reg_re,
	output logic      [7:0]                    reg_rdata,
	input  wire logic                          local_valid,
	input  wire logic [tla_pkg::TEMP_W-1:0]    local_result,
	input  wire logic                          remote_valid,
	input  wire logic [tla_pkg::TEMP_W-1:0]    remote_raw,
	input  wire logic                          conv_start,
	input  wire logic                          sensor_open,
	input  wire logic                          alert_response_addr,
	output logic                               ara_ack,
	output logic      [7:0]                    ara_data,
	output logic                               shared_pin_oe,
	output logic                               failsafe_trip_n_oe,
	output logic                               comp_disable
);
	import tla_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Register state

	logic [TEMP_W-1:0] temp_q  [NCH];
	logic [TEMP_W-1:0] high_q  [NCH];
	logic [TEMP_W-1:0] low_q   [NCH];
	logic [TEMP_W-1:0] trip_q  [NCH];
	logic [HYST_W-1:0] hyst_q;
	logic [TEMP_W-1:0] offset_q;
	logic [7:0]        config_q;
	logic [ST_W-1:0]   status_q;
	logic              open_q;
	logic [NCH-1:0]    fs_q;
	logic [NCH-1:0]    sec_q;
	logic [NCH-1:0]    over_high;
	logic [NCH-1:0]    at_low;
	logic [NCH-1:0]    over_trip;
	logic [NCH-1:0]    fs_rel;
	logic [NCH-1:0]    sec_rel;
	logic [ST_W-1:0]   st_set;
	logic              cond_any;
	logic              wr_status;
	logic              alarm_on;
	logic              sel_trip;
	logic              mask_on;
	logic              svc_take;
	logic              alarm_drive;
	logic signed [TEMP_W:0] rem_sum;
	logic [TEMP_W-1:0] rem_corr;
	tla_alert_t        alert_q;
	tla_alert_t        alert_d;

	assign sel_trip  = config_q[CFG_SEL_BIT];
	assign mask_on   = config_q[CFG_MASK_BIT];
	assign wr_status = reg_we && (reg_addr == OFF_STATUS);

	// Service counts only while the pin is really pulled low, so a
	// response read racing the first low cycle cannot retire an alarm
	assign svc_take = alert_response_addr && shared_pin_oe
		&& !sel_trip && !mask_on; // [RL4] [RL17] [RL19]

	// A masked alarm stays latched and shows once the mask is lifted
	assign alarm_drive = alarm_on && !mask_on; // [RL19]

	////////////////////////////////////////////////////////////////////
	// Remote offset correction with saturation
	// Nine-bit sum, so a large correction clips rather than wraps

	always_comb begin
		rem_sum = $signed({remote_raw[TEMP_W-1], remote_raw})
			+ $signed({offset_q[TEMP_W-1], offset_q}); // [RL16]
		if (rem_sum > SAT_MAX) begin
			rem_corr = SAT_MAX[TEMP_W-1:0];
		end else if (rem_sum < SAT_MIN) begin
			rem_corr = SAT_MIN[TEMP_W-1:0];
		end else begin
			rem_corr = rem_sum[TEMP_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			temp_q[CH_LOC] <= RST_TEMP;
			temp_q[CH_REM] <= RST_TEMP;
		end else begin
			if (local_valid) begin
				temp_q[CH_LOC] <= local_result;
			end
			if (remote_valid) begin
				temp_q[CH_REM] <= rem_corr; // [RL16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Limit registers

	always_ff @(posedge clk) begin
		if (rst) begin
			high_q[CH_LOC] <= RST_HIGH;
			high_q[CH_REM] <= RST_HIGH;
			low_q[CH_LOC]  <= RST_LOW;
			low_q[CH_REM]  <= RST_LOW;
			trip_q[CH_LOC] <= RST_TRIP; // [RL8]
			trip_q[CH_REM] <= RST_TRIP; // [RL8]
			hyst_q         <= RST_HYST; // [RL9]
			offset_q       <= RST_OFFSET;
		end else if (reg_we) begin
			case (reg_addr)
				OFF_LOCAL_HIGH:  high_q[CH_LOC] <= reg_wdata;
				OFF_LOCAL_LOW:   low_q[CH_LOC]  <= reg_wdata;
				OFF_REMOTE_HIGH: high_q[CH_REM] <= reg_wdata;
				OFF_REMOTE_LOW:  low_q[CH_REM]  <= reg_wdata;
				OFF_LOCAL_TRIP:  trip_q[CH_LOC] <= reg_wdata;
				OFF_REMOTE_TRIP: trip_q[CH_REM] <= reg_wdata;
				OFF_HYST:        hyst_q <= reg_wdata[HYST_W-1:0]; // [RL9]
				OFF_OFFSET:      offset_q <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Only bits 7, 5 and 4 are writable; bit 3 always reads one
	always_ff @(posedge clk) begin
		if (rst) begin
			config_q <= RST_CONFIG;
		end else if (reg_we && reg_addr == OFF_CONFIG) begin
			config_q <= (reg_wdata & CFG_WR_MASK)
				| (RST_CONFIG & ~CFG_WR_MASK);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			comp_disable <= 1'b0;
		end else begin
			comp_disable <= config_q[CFG_COMP_BIT]; // [RL15]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-channel comparisons, evaluated every cycle on stored values

	// Floors carry two spare bits so limit minus hysteresis cannot wrap
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic signed [TEMP_W+1:0] t_ext;
			logic signed [TEMP_W+1:0] fs_floor;
			logic signed [TEMP_W+1:0] sec_floor;
			assign t_ext = $signed({{2{temp_q[ch][TEMP_W-1]}},
				temp_q[ch]});
			assign fs_floor = $signed({{2{trip_q[ch][TEMP_W-1]}},
				trip_q[ch]}) - $signed({5'h00, hyst_q}); // [RL7]
			assign sec_floor = $signed({{2{high_q[ch][TEMP_W-1]}},
				high_q[ch]}) - $signed({5'h00, hyst_q}); // [RL13]
			assign over_high[ch] = $signed(temp_q[ch])
				> $signed(high_q[ch]); // [RL1] [RL21]
			assign at_low[ch] = $signed(temp_q[ch])
				<= $signed(low_q[ch]); // [RL2] [RL21]
			assign over_trip[ch] = $signed(temp_q[ch])
				> $signed(trip_q[ch]); // [RL6] [RL21]
			assign fs_rel[ch]  = t_ext <= fs_floor;
			assign sec_rel[ch] = t_ext <= sec_floor;

			always_ff @(posedge clk) begin
				if (rst) begin
					fs_q[ch]  <= 1'b0;
					sec_q[ch] <= 1'b0;
				end else begin
					if (over_trip[ch]) begin
						fs_q[ch] <= 1'b1; // [RL6]
					end else if (fs_rel[ch]) begin
						fs_q[ch] <= 1'b0; // [RL7]
					end
					if (over_high[ch]) begin
						sec_q[ch] <= 1'b1; // [RL12]
					end else if (sec_rel[ch]) begin
						sec_q[ch] <= 1'b0; // [RL13]
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Open-sensor check and status flags
	// The open condition holds until a conversion finds the sensor back

	always_ff @(posedge clk) begin
		if (rst) begin
			open_q <= 1'b0;
		end else if (conv_start) begin
			open_q <= sensor_open; // [RL18]
		end
	end

	always_comb begin
		st_set              = '0;
		st_set[ST_LOC_LOW]  = at_low[CH_LOC];
		st_set[ST_LOC_HIGH] = over_high[CH_LOC];
		st_set[ST_OPEN]     = conv_start && sensor_open; // [RL18]
		st_set[ST_REM_LOW]  = at_low[CH_REM];
		st_set[ST_REM_HIGH] = over_high[CH_REM];
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= '0;
		end else if (wr_status) begin
			status_q <= (status_q & ~reg_wdata[ST_W-1:0]) | st_set;
		end else begin
			status_q <= status_q | st_set;
		end
	end

	assign cond_any = (|over_high) || (|at_low) || open_q; // [RL1] [RL2] [RL3]

	////////////////////////////////////////////////////////////////////
	// Alarm state: latched until serviced, condition gone, flags clear

	always_comb begin
		alert_d = alert_q;
		case (alert_q)
			TLA_IDLE: begin
				if (cond_any || status_q != '0) begin
					alert_d = TLA_ASSERTED; // [RL1] [RL2] [RL3]
				end
			end
			TLA_ASSERTED: begin
				if (svc_take) begin
					alert_d = TLA_SERVICED; // [RL4]
				end
			end
			TLA_SERVICED: begin
				// Pin stays low until the cause and every flag are gone
				if (!cond_any && status_q == '0) begin
					alert_d = TLA_IDLE; // [RL4]
				end
			end
			default: alert_d = TLA_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alert_q <= TLA_IDLE;
		end else begin
			alert_q <= alert_d;
		end
	end

	assign alarm_on = alert_q != TLA_IDLE;

	// Answer to the alert response read while the shared pin is driven low, in either pin mode
	always_ff @(posedge clk) begin
		if (rst) begin
			ara_ack  <= 1'b0;
			ara_data <= 8'h00;
		end else begin
			ara_ack  <= alert_response_addr && shared_pin_oe; // [RL17]
			ara_data <= alert_response_addr && shared_pin_oe
				? {DEV_ADDR, 1'b1} : 8'h00; // [RL17]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Open-drain pull-down enables

	always_ff @(posedge clk) begin
		if (rst) begin
			failsafe_trip_n_oe <= 1'b0;
			shared_pin_oe      <= 1'b0;
		end else begin
			failsafe_trip_n_oe <= |fs_q; // [RL5] [RL14] [RL22]
			if (sel_trip) begin
				shared_pin_oe <= |sec_q; // [RL11] [RL12] [RL14] [RL20]
			end else begin
				shared_pin_oe <= alarm_drive; // [RL19] [RL4] [RL22]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe
	// Unmapped bits read as zero; reserved configuration bit 3 reads one

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
				OFF_LOCAL_TEMP:  reg_rdata <= temp_q[CH_LOC];
				OFF_REMOTE_TEMP: reg_rdata <= temp_q[CH_REM];
				OFF_STATUS:      reg_rdata <= {3'h0, status_q};
				OFF_CONFIG:      reg_rdata <= config_q;
				OFF_LOCAL_HIGH:  reg_rdata <= high_q[CH_LOC];
				OFF_LOCAL_LOW:   reg_rdata <= low_q[CH_LOC];
				OFF_REMOTE_HIGH: reg_rdata <= high_q[CH_REM];
				OFF_REMOTE_LOW:  reg_rdata <= low_q[CH_REM];
				OFF_LOCAL_TRIP:  reg_rdata <= trip_q[CH_LOC];
				OFF_REMOTE_TRIP: reg_rdata <= trip_q[CH_REM];
				OFF_HYST:        reg_rdata <= {3'h0, hyst_q};
				OFF_OFFSET:      reg_rdata <= offset_q;
				default:         reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// ===== tb/tla_alarm_properties.sv
// Port-level assertions for the temperature alarm logic
`timescale 1ns/1ps
module tla_alarm_chk
	import tla_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_we,
	input wire logic              local_valid,
	input wire logic              remote_valid,
	input wire logic              alert_response_addr,
	input wire logic              ara_ack,
	input wire logic [7:0]        ara_data,
	input wire logic              shared_pin_oe,
	input wire logic              failsafe_trip_n_oe,
	input wire logic              comp_disable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic cfg_wr;
	logic sel_q;
	logic mask_q;
	logic oe_prev_q;
	logic svc_q;

	assign cfg_wr = reg_we && reg_addr == OFF_CONFIG;

	// Mirror of pin mode and mask, and whether this episode was serviced
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q     <= RST_CONFIG[CFG_SEL_BIT];
			mask_q    <= RST_CONFIG[CFG_MASK_BIT];
			oe_prev_q <= 1'b0;
			svc_q     <= 1'b0;
		end else begin
			if (cfg_wr) begin
				sel_q  <= reg_wdata[CFG_SEL_BIT];
				mask_q <= reg_wdata[CFG_MASK_BIT];
			end
			oe_prev_q <= shared_pin_oe;
			if (ara_ack) begin
				svc_q <= 1'b1;
			end else if (shared_pin_oe && !oe_prev_q) begin
				svc_q <= 1'b0;
			end
		end
	end

	ack_data_a: assert property (
		ara_ack |-> ara_data == {DEV_ADDR, 1'b1}) else $error("bad ack data");
	ack_cause_a: assert property (
		ara_ack |-> $past(alert_response_addr) && $past(shared_pin_oe))
		else $error("ack without request");
	serv_release_a: assert property (
		$fell(shared_pin_oe) && !sel_q && !mask_q
		&& !$past(cfg_wr) && !$past(cfg_wr, 2) |-> svc_q)
		else $error("alarm released without service");
	cfg_set_a: assert property (
		reg_we && reg_addr == OFF_CONFIG && reg_wdata[4] ##1
		!(reg_we && reg_addr == OFF_CONFIG) |=> comp_disable)
		else $error("compensation not disabled");
	cfg_clr_a: assert property (
		reg_we && reg_addr == OFF_CONFIG && !reg_wdata[4] ##1
		!(reg_we && reg_addr == OFF_CONFIG) |=> !comp_disable)
		else $error("compensation not enabled");
	trip_rise_a: assert property (
		$rose(failsafe_trip_n_oe) |-> $past(local_valid, 3) ||
		$past(remote_valid, 3) || $past(reg_we, 3))
		else $error("trip without new value");
	trip_fall_a: assert property (
		$fell(failsafe_trip_n_oe) |-> $past(local_valid, 3) ||
		$past(remote_valid, 3) || $past(reg_we, 3))
		else $error("trip release without new value");
	rst_quiet_a: assert property (
		$fell(rst) |-> !shared_pin_oe && !failsafe_trip_n_oe && !ara_ack)
		else $error("pin driven after reset");
endmodule

bind tla_alarm tla_alarm_chk #(
	.DEV_ADDR(DEV_ADDR)
) u_tla_alarm_chk (
	.clk                 (clk),
	.rst                 (rst),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_we              (reg_we),
	.local_valid         (local_valid),
	.remote_valid        (remote_valid),
	.alert_response_addr (alert_response_addr),
	.ara_ack             (ara_ack),
	.ara_data            (ara_data),
	.shared_pin_oe       (shared_pin_oe),
	.failsafe_trip_n_oe  (failsafe_trip_n_oe),
	.comp_disable        (comp_disable)
);

// ===== tb/tla_host.sv
// Host model that services the alarm line with alert-response reads
`timescale 1ns/1ps
module tla_host #(
	parameter logic [3:0] LAG = 4'h6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic shared_pin_oe,
	output logic     alert_response_addr
);
	logic [3:0] wait_q;

	always_ff @(posedge clk) begin
		if (rst || !en || !shared_pin_oe) begin
			wait_q <= 4'h0;
			alert_response_addr <= 1'b0;
		end else begin
			alert_response_addr <= (wait_q == LAG);
			wait_q <= (wait_q == LAG) ? 4'h0 : wait_q + 4'h1;
		end
	end
endmodule

// ===== tb/tb_tla_alarm.sv
// Self-checking bench for the temperature alarm logic
`timescale 1ns/1ps
module tb_tla_alarm;
	import tla_pkg::*;
	localparam logic [6:0] DEV = 7'h2A; // Arbitrary address
	logic              clk = 0;
	logic              rst = 1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [7:0]        reg_wdata = '0;
	logic [7:0]        reg_rdata, ara_data;
	logic              reg_we = 0, reg_re = 0;
	logic              local_valid = 0, remote_valid = 0;
	logic [7:0]        temp = '0;
	logic              conv_start = 0, sensor_open = 0, host_en = 0;
	logic              alert_response_addr, ara_ack;
	logic              shared_pin_oe, failsafe_trip_n_oe, comp_disable;
	int                err_count = 0, compares = 0;

	tla_alarm #(.DEV_ADDR(DEV)) u_tla_alarm (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .local_valid(local_valid),
		.local_result(temp), .remote_valid(remote_valid), .remote_raw(temp),
		.conv_start(conv_start), .sensor_open(sensor_open),
		.alert_response_addr(alert_response_addr), .ara_ack(ara_ack),
		.ara_data(ara_data), .shared_pin_oe(shared_pin_oe),
		.failsafe_trip_n_oe(failsafe_trip_n_oe), .comp_disable(comp_disable));
	tla_host u_tla_host (.clk(clk), .rst(rst), .en(host_en),
		.shared_pin_oe(shared_pin_oe),
		.alert_response_addr(alert_response_addr));

	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		reg_we <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		reg_re <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask
	task automatic feed(logic l, logic [7:0] t);
		@(posedge clk);
		temp <= t;
		local_valid <= l;
		remote_valid <= !l;
		@(posedge clk);
		local_valid <= 0;
		remote_valid <= 0;
	endtask
	task automatic pins(logic s, logic f);
		repeat (4) @(posedge clk);
		#1;
		chk("pins", {6'h0, s, f}, {6'h0, shared_pin_oe, failsafe_trip_n_oe});
	endtask
	// Reset, move low limits away from zero, let the host clear the alarm
	task automatic setup;
		@(posedge clk);
		rst <= 1;
		host_en <= 1;
		repeat (12) @(posedge clk);
		rst <= 0;
		wr(OFF_LOCAL_LOW, 8'h80);
		wr(OFF_REMOTE_LOW, 8'h80);
		wr(OFF_CONFIG, 8'h00);
		repeat (12) @(posedge clk);
		wr(OFF_STATUS, 8'h1F);
		repeat (12) @(posedge clk);
		host_en <= 0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		rd(OFF_CONFIG, 8'h08);
		rd(OFF_LOCAL_TRIP, 8'h55);
		rd(OFF_REMOTE_TRIP, 8'h55);
		rd(OFF_HYST, 8'h0A);
		wr(OFF_HYST, 8'hFF);
		rd(OFF_HYST, 8'h1F);
		$display("defaults done");
	endtask
	task automatic t_trip;
		setup();
		feed(1, 8'h55);
		pins(0, 0);
		feed(1, 8'h56);
		pins(1, 1);
		feed(1, 8'h4C);
		pins(1, 1);
		feed(1, 8'h4B);
		pins(1, 0);
		feed(0, 8'h56);
		pins(1, 1);
		wr(OFF_HYST, 8'h00);
		feed(0, 8'h55);
		pins(1, 0);
		$display("trip done");
	endtask
	task automatic t_alarm;
		setup();
		feed(1, 8'h60);
		host_en <= 1;
		for (int i = 0; i < 30 && ara_ack !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("ara_data", {DEV, 1'b1}, ara_data);
		@(posedge clk);
		host_en <= 0;
		#1;
		chk("held", 8'h01, {7'h0, shared_pin_oe});
		feed(1, 8'h20);
		pins(1, 0);
		wr(OFF_STATUS, 8'h1F);
		rd(OFF_STATUS, 8'h00);
		pins(0, 0);
		feed(1, 8'h60);
		pins(1, 1);
		$display("alarm done");
	endtask
	task automatic t_low;
		setup();
		feed(1, 8'h21);
		wr(OFF_LOCAL_LOW, 8'h20);
		pins(0, 0);
		wr(OFF_LOCAL_LOW, 8'h21);
		pins(1, 0);
		rd(OFF_STATUS, 8'h01);
		$display("low done");
	endtask
	task automatic t_modes;
		setup();
		wr(OFF_CONFIG, 8'h80);
		feed(1, 8'h60);
		pins(0, 1);
		setup();
		wr(OFF_CONFIG, 8'hA0);
		wr(OFF_REMOTE_HIGH, 8'h30);
		feed(0, 8'h31);
		pins(1, 0);
		feed(0, 8'h27);
		pins(1, 0);
		feed(0, 8'h26);
		pins(0, 0);
		$display("modes done");
	endtask
	task automatic t_open;
		setup();
		@(posedge clk);
		sensor_open <= 1;
		conv_start <= 1;
		@(posedge clk);
		conv_start <= 0;
		sensor_open <= 0;
		pins(1, 0);
		rd(OFF_STATUS, 8'h04);
		$display("open done");
	endtask
	task automatic t_offset;
		setup();
		wr(OFF_OFFSET, 8'hFE);
		feed(0, 8'h57);
		pins(0, 0);
		rd(OFF_REMOTE_TEMP, 8'h55);
		wr(OFF_CONFIG, 8'h10);
		pins(0, 0);
		chk("comp", 8'h01, {7'h0, comp_disable});
		rd(OFF_CONFIG, 8'h18);
		feed(0, 8'h80);
		rd(OFF_REMOTE_TEMP, 8'h80);
		$display("offset done");
	endtask

	task automatic print_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		err_count++;
		$display("[ERR] watchdog exp done got hang");
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		t_defaults();
		t_trip();
		t_alarm();
		t_low();
		t_modes();
		t_open();
		t_offset();
		print_verdict();
	end
endmodule
